//--- verilog/spdif_in_pkg.sv
// shared constants and types of the s/pdif transmitter serial input port
// assumes a single 125 MHz clock and an apb register bus
package spdif_in_pkg;

	// ***************************************************
	// register map, byte addresses
	// ***************************************************
	localparam logic [3:0] ctrl_addr   = 4'h0;
	localparam logic [3:0] status_addr = 4'h4;
	localparam logic [3:0] left_addr   = 4'h8;
	localparam logic [3:0] right_addr  = 4'hC;

	// ***************************************************
	// control and status fields
	// ***************************************************
	localparam int ctrl_en_bit    = 0;
	localparam int ctrl_fmt_lo    = 1;
	localparam int ctrl_width_lo  = 3;
	localparam int ctrl_ratio_bit = 5;
	localparam int status_ovr_bit = 0;
	localparam int status_lvl_bit = 1;

	// ***************************************************
	// modes
	// ***************************************************
	typedef enum logic [1:0] {
		fmt_right = 2'h0,
		fmt_i2s   = 2'h1,
		fmt_left  = 2'h2
	} fmt_t;

	typedef enum logic [1:0] {
		width_16 = 2'h0,
		width_18 = 2'h1,
		width_20 = 2'h2,
		width_24 = 2'h3
	} width_t;

	localparam logic [5:0] ctrl_reset = 6'h02; // enable off, i2s, 16 bit, 256x

	// ***************************************************
	// framing and clock ratios
	// ***************************************************
	localparam int          sample_bits       = 24;
	localparam logic [5:0]  half_frame_bits   = 6'h20; // 64 bit clocks per frame
	localparam int          osr_high          = 384;
	localparam int          osr_low           = 256;
	localparam int          biphase_per_frame = 128;
	localparam logic [1:0]  div_high          = 2'(osr_high / biphase_per_frame);
	localparam logic [1:0]  div_low           = 2'(osr_low / biphase_per_frame);

	typedef struct packed {
		logic [sample_bits-1:0] left;
		logic [sample_bits-1:0] right;
	} sample_pair_t;

endpackage

//--- verilog/biphase_divider.sv
// divides oversampling clock edges down to the biphase clock enable
// assumes tick_i is a one-cycle pulse per oversampling clock rising edge
`timescale 1ns/1ps
module biphase_divider
	import spdif_in_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       tick_i,
	input  wire logic       ratio_high_i,
	output logic            biphase_en_o
);

	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic [1:0] div_sel;
	logic       wrap;

	// ***************************************************
	// divide by 3 for 384x, by 2 for 256x
	// ***************************************************
	assign div_sel  = ratio_high_i ? div_high : div_low; // R8
	assign wrap     = tick_i && (cnt_reg == div_sel - 2'h1);
	assign cnt_next = wrap ? 2'h0 : cnt_reg + 2'h1;

	// counter and enable pulse
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg      <= 2'h0;
			biphase_en_o <= 1'b0;
		end else begin
			biphase_en_o <= wrap; // R8
			if (tick_i) begin
				cnt_reg <= cnt_next;
			end
		end
	end

endmodule

//--- verilog/pair_buffer.sv
// small fifo for sample pairs, head entry drives the output directly
// assumes the drain side may stall freely
`timescale 1ns/1ps
module pair_buffer #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 2
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_b_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [CW-1:0]    level_reg;
	logic [CW-1:0]    level_after_pop;
	logic [CW-1:0]    level_next;
	logic             valid_reg;
	logic             push;
	logic             pop;

	assign push            = in_valid_i && in_ready_o;
	assign pop             = out_valid_o && out_ready_i;
	assign level_after_pop = pop ? level_reg - CW'(1) : level_reg;
	assign in_ready_o      = (level_reg != CW'(DEPTH));
	assign level_next      = level_after_pop + (push ? CW'(1) : CW'(0));
	assign out_valid_o     = valid_reg; // straight from a flip-flop
	assign out_data_o      = mem_reg[0];

	// entries shift toward the head on every pop
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge mclk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				mem_reg[i] <= '0;
			end else if (push && level_after_pop == CW'(i)) begin
				mem_reg[i] <= in_data_i;
			end else if (pop && i < DEPTH - 1) begin
				mem_reg[i] <= mem_reg[(i + 1) % DEPTH];
			end
		end
	end

	// fill level and registered non-empty flag
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			level_reg <= level_next;
			valid_reg <= (level_next != '0);
		end
	end

endmodule

//--- verilog/spdif_serial_input.sv
// serial audio input port of an s/pdif transmitter with apb registers
// assumes bit clock, word clock, data and oversampling clock are already
// synchronous to mclk_i and each stays stable for at least one mclk cycle
//
// Functional notes
// R1 - accepts left-justified, i2s or right-justified input, 16/18/20/24 bit words
// R2 - data bits are sampled on the bit clock rising edge in all formats
// R3 - right-justified: word clock high left; msb 32 minus width bits after edge
// R4 - right-justified with 64 bit clocks per frame: lsb ends at next edge
// R5 - i2s: word clock low left; msb one bit clock after each edge
// R6 - i2s is the format selected out of reset
// R7 - left-justified: word clock high left; msb right at the edge
// R8 - biphase clock enable divides oversampling clock, 384x or 256x frame rate
// R9 - bits shift msb first per channel; full pair goes to the core
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module spdif_serial_input
	import spdif_in_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [3:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// serial source
	input  wire logic        bit_clock_i,
	input  wire logic        word_clock_i,
	input  wire logic        serial_sample_line_i,
	input  wire logic        oversampling_clock_i,
	// transmitter core
	output logic             biphase_en_o,
	output logic             pair_valid_o,
	input  wire logic        pair_ready_i,
	output sample_pair_t     pair_o
);

	// ***************************************************
	// registers and state
	// ***************************************************
	logic [5:0]             ctrl_reg;
	logic                   ovr_reg;
	logic                   bclk_prev_reg;
	logic                   osc_prev_reg;
	logic                   ws_prev_reg;
	logic [5:0]             cnt_reg;
	logic [sample_bits-1:0] shift_reg;
	logic [sample_bits-1:0] left_reg;
	logic [sample_bits-1:0] right_reg;
	logic                   left_ok_reg;
	logic                   push_reg;
	logic [31:0]            prdata_reg;
	logic                   pready_reg;
	logic                   pslverr_reg;

	// ***************************************************
	// decode of control fields
	// ***************************************************
	logic       enable;
	fmt_t       fmt;
	width_t     width;
	logic       ratio_high;
	logic [5:0] wbits;
	logic [5:0] start_bit;
	logic [5:0] last_bit;

	assign enable     = ctrl_reg[ctrl_en_bit];
	assign fmt        = fmt_t'(ctrl_reg[ctrl_fmt_lo +: 2]);
	assign width      = width_t'(ctrl_reg[ctrl_width_lo +: 2]);
	assign ratio_high = ctrl_reg[ctrl_ratio_bit];

	// word length per width code
	assign wbits = (width == width_16) ? 6'h10 :
	               (width == width_18) ? 6'h12 :
	               (width == width_20) ? 6'h14 : 6'h18; // R1

	// first data bit position after a word clock edge
	assign start_bit = (fmt == fmt_right) ? half_frame_bits - wbits : // R3 R4
	                   (fmt == fmt_left)  ? 6'h00 :                   // R7
	                                        6'h01;                    // R5
	assign last_bit  = start_bit + wbits - 6'h01;

	// ***************************************************
	// serial capture
	// ***************************************************
	logic                   bclk_rise;
	logic                   ws_edge;
	logic [5:0]             bit_pos;
	logic                   in_word;
	logic                   word_done;
	logic                   is_left;
	logic [sample_bits-1:0] shift_next;
	logic [sample_bits-1:0] word_aligned;
	logic [4:0]             align_sh;

	assign bclk_rise    = bit_clock_i && !bclk_prev_reg; // R2
	assign ws_edge      = word_clock_i != ws_prev_reg;
	assign bit_pos      = ws_edge ? 6'h00 : cnt_reg;
	assign in_word      = (bit_pos >= start_bit) && (bit_pos <= last_bit);
	assign word_done    = enable && bclk_rise && (bit_pos == last_bit);
	// unused format code 3 runs as i2s, so only right and left take the high level
	assign is_left      = (fmt == fmt_right || fmt == fmt_left) ? word_clock_i :
	                      !word_clock_i; // R3 R5 R7
	assign shift_next   = {shift_reg[sample_bits-2:0], serial_sample_line_i}; // R9
	assign align_sh     = 5'(6'(sample_bits) - wbits);
	assign word_aligned = shift_next << align_sh;

	// edge trackers and bit counter
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bclk_prev_reg <= 1'b0;
			ws_prev_reg   <= 1'b0;
			cnt_reg       <= 6'h00;
		end else begin
			bclk_prev_reg <= bit_clock_i;
			if (bclk_rise) begin
				ws_prev_reg <= word_clock_i;
				cnt_reg     <= (bit_pos == 6'h3F) ? bit_pos : bit_pos + 6'h01;
			end
		end
	end

	// msb-first shifter, channel words left aligned
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_reg <= '0;
		end else if (enable && bclk_rise && in_word) begin
			shift_reg <= shift_next; // R2 R9
		end
	end

	// channel holding and pair completion
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			left_reg    <= '0;
			right_reg   <= '0;
			left_ok_reg <= 1'b0;
			push_reg    <= 1'b0;
		end else begin
			push_reg <= word_done && !is_left && left_ok_reg; // R9
			if (!enable) begin
				left_ok_reg <= 1'b0;
			end else if (word_done && is_left) begin
				left_reg    <= word_aligned;
				left_ok_reg <= 1'b1;
			end else if (word_done) begin
				right_reg   <= word_aligned;
				left_ok_reg <= 1'b0;
			end
		end
	end

	// ***************************************************
	// pair buffer toward the transmitter core
	// ***************************************************
	sample_pair_t pair_in;
	logic         buf_ready;
	logic         lost;

	assign pair_in.left  = left_reg;
	assign pair_in.right = right_reg;
	assign lost          = push_reg && !buf_ready;

	pair_buffer #(
		.WIDTH ($bits(sample_pair_t)),
		.DEPTH (2)
	) u_buf (
		.mclk_i      (mclk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (push_reg),
		.in_ready_o  (buf_ready),
		.in_data_i   (pair_in),
		.out_valid_o (pair_valid_o),
		.out_ready_i (pair_ready_i),
		.out_data_o  (pair_o)
	);

	// ***************************************************
	// biphase clock enable
	// ***************************************************
	logic osc_rise;

	assign osc_rise = oversampling_clock_i && !osc_prev_reg;

	// oversampling edge tracker
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			osc_prev_reg <= 1'b0;
		end else begin
			osc_prev_reg <= oversampling_clock_i;
		end
	end

	biphase_divider u_div (
		.mclk_i       (mclk_i),
		.rst_b_i      (rst_b_i),
		.tick_i       (osc_rise),
		.ratio_high_i (ratio_high),
		.biphase_en_o (biphase_en_o)
	);

	// ***************************************************
	// apb slave
	// ***************************************************
	logic        setup;
	logic        wr_take;
	logic        hit_ctrl;
	logic        hit_status;
	logic        hit_left;
	logic        hit_right;
	logic        mapped;
	logic [31:0] rd_mux;

	assign setup      = psel_i && !penable_i;
	assign wr_take    = psel_i && penable_i && pready_reg && pwrite_i;
	assign hit_ctrl   = (paddr_i == ctrl_addr);
	assign hit_status = (paddr_i == status_addr);
	assign hit_left   = (paddr_i == left_addr);
	assign hit_right  = (paddr_i == right_addr);
	assign mapped     = hit_ctrl || hit_status || hit_left || hit_right;

	// read data select, reserved bits zero
	assign rd_mux = hit_ctrl   ? {26'h0, ctrl_reg} :
	                hit_status ? {30'h0, pair_valid_o, ovr_reg} :
	                hit_left   ? {8'h0, left_reg} :
	                hit_right  ? {8'h0, right_reg} : 32'h0;

	// answer in the first access cycle
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && !mapped;
			prdata_reg  <= (setup && !pwrite_i) ? rd_mux : 32'h0;
		end
	end

	// control write, overrun flag with set over clear
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_reg <= ctrl_reset; // R6
			ovr_reg  <= 1'b0;
		end else begin
			if (wr_take && hit_ctrl) begin
				ctrl_reg <= pwdata_i[5:0]; // R1
			end
			if (lost) begin
				ovr_reg <= 1'b1;
			end else if (wr_take && hit_status && pwdata_i[status_ovr_bit]) begin
				ovr_reg <= 1'b0;
			end
		end
	end

	assign prdata_o  = prdata_reg;
	assign pready_o  = pready_reg;
	assign pslverr_o = pslverr_reg;

endmodule

//--- bench/spdif_serial_input_properties.sv
// checker for the serial input port, sees only its top ports
// assumes one clock domain and the zero-wait apb slave of the design
`timescale 1ns/1ps
module spdif_serial_input_properties
	import spdif_in_pkg::*;
(
	input wire logic         mclk_i,
	input wire logic         rst_b_i,
	input wire logic         psel_i,
	input wire logic         penable_i,
	input wire logic         pwrite_i,
	input wire logic [3:0]   paddr_i,
	input wire logic [31:0]  pwdata_i,
	input wire logic [31:0]  prdata_o,
	input wire logic         pready_o,
	input wire logic         pslverr_o,
	input wire logic         bit_clock_i,
	input wire logic         word_clock_i,
	input wire logic         serial_sample_line_i,
	input wire logic         oversampling_clock_i,
	input wire logic         biphase_en_o,
	input wire logic         pair_valid_o,
	input wire logic         pair_ready_i,
	input wire sample_pair_t pair_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	// ****************************************
	// properties
	// ****************************************
	// biphase pulses need at least two oversampling edges
	biphase_gap_a: assert property (biphase_en_o |=> !biphase_en_o [*3])
		else $error("biphase pulses too close");
	// a stalled pair stays put
	pair_hold_a: assert property (pair_valid_o && !pair_ready_i |=> pair_valid_o && $stable(pair_o))
		else $error("pair changed while stalled");
	// a pair leaves only when taken
	pair_taken_a: assert property ($fell(pair_valid_o) |-> $past(pair_ready_i))
		else $error("pair lost without handshake");
	// a new pair follows a sampled bit
	pair_bit_a: assert property ($rose(pair_valid_o) |-> $past(bit_clock_i, 2) ||
		$past(bit_clock_i, 3) || $past(bit_clock_i, 4))
		else $error("pair not tied to bit edge");
	apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready in access cycle");
	pready_cause_a: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
		else $error("ready without setup");
	pready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	error_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside access");
	cover property (pair_valid_o && pair_ready_i);
	cover property (pair_valid_o && !pair_ready_i [*8]);
	cover property (pslverr_o);
	cover property (biphase_en_o);
endmodule

//--- bench/audio_source_model.sv
// behavioural serial audio source: bit clock, word clock, data line
// assumes 64 bit clocks per frame at four mclk cycles per bit
`timescale 1ns/1ps
module audio_source_model
	import spdif_in_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        run_i,
	input  wire fmt_t        fmt_i,
	input  wire width_t      width_i,
	input  wire logic [23:0] left_i,
	input  wire logic [23:0] right_i,
	output logic             frame_o,
	output logic             bit_clock_o,
	output logic             word_clock_o,
	output logic             serial_sample_line_o
);
	logic [7:0]  cnt_reg;
	logic [23:0] left_reg;
	logic [23:0] right_reg;
	logic [23:0] word;
	logic        tog_reg;
	logic [5:0]  wbits;
	logic [5:0]  start;
	logic [5:0]  k;
	// ****************************************
	// framing
	// ****************************************
	// word slot of the current bit position
	assign wbits = (width_i == width_24) ? 6'h18 : 6'h10 + {3'h0, width_i, 1'b0};
	assign start = (fmt_i == fmt_left) ? 6'h0 : (fmt_i == fmt_i2s) ? 6'h1 : 6'h20 - wbits;
	assign k     = {1'b0, cnt_reg[6:2]} - start;
	assign word  = cnt_reg[7] ? right_reg : left_reg;
	// bit clock stands low when stopped; word clock marks the channel
	assign bit_clock_o  = run_i & cnt_reg[1];
	assign word_clock_o = cnt_reg[7] ^ (fmt_i != fmt_i2s);
	assign frame_o      = run_i && cnt_reg == 8'hFF;
	// msb first, changes on bit clock fall; spare bits keep toggling
	assign serial_sample_line_o = !run_i ? tog_reg :
		(k < wbits) ? word[5'(wbits - 6'h1 - k)] : cnt_reg[2];
	// slot counter, samples latched at frame start
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg   <= 8'h80;
			left_reg  <= 24'h0;
			right_reg <= 24'h0;
			tog_reg   <= 1'b0;
		end else begin
			tog_reg <= ~tog_reg;
			cnt_reg <= run_i ? cnt_reg + 8'h1 : 8'h80;
			if (cnt_reg == 8'hFF) begin
				left_reg  <= left_i;
				right_reg <= right_i;
			end
		end
	end
endmodule

//--- bench/tb_spdif_tx_serial_input_port.sv
// self-checking bench for the serial input port
// assumes the source model and checker files are compiled first
`timescale 1ns/1ps
module tb_spdif_tx_serial_input_port;
	import spdif_in_pkg::*;
	logic         mclk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [3:0]   paddr_i;
	logic [31:0]  pwdata_i, prdata_o;
	logic         bit_clock_i, word_clock_i, serial_sample_line_i, oversampling_clock_i;
	logic         biphase_en_o, pair_valid_o, pair_ready_i, run, hold, frame;
	sample_pair_t pair_o;
	fmt_t         fmt;
	width_t       wid;
	logic [23:0]  lw, rw;
	logic [1:0]   exp_div;
	logic [47:0]  expq[$];
	int           error_cnt, tests_run, cyc, gap, bp_seen;

	spdif_serial_input dut (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .bit_clock_i, .word_clock_i,
		.serial_sample_line_i, .oversampling_clock_i, .biphase_en_o, .pair_valid_o,
		.pair_ready_i, .pair_o);
	audio_source_model src (.mclk_i, .rst_b_i, .run_i(run), .fmt_i(fmt), .width_i(wid),
		.left_i(lw), .right_i(rw), .frame_o(frame), .bit_clock_o(bit_clock_i),
		.word_clock_o(word_clock_i), .serial_sample_line_o(serial_sample_line_i));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one apb transfer, waits for ready under a bound
	task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic err);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (!wr) check(prdata_o, exp);
		check({pslverr_o, pready_o}, {err, 1'b1});
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// n frames in one mode; the first keep pairs are expected
	task automatic run_mode(input fmt_t f, input width_t w, input int n, input int keep);
		int wb;
		logic [23:0] a, b;
		wb = (w == width_24) ? 24 : 16 + 2 * int'(w);
		apb(1'b1, ctrl_addr, {26'h0, w[0], w, f, 1'b1}, 32'h0, 1'b0);
		exp_div <= w[0] ? div_high : div_low;
		bp_seen = 0;
		fmt <= f;
		wid <= w;
		run <= 1'b1;
		for (int i = 0; i < n; i++) begin
			a = 24'($urandom);
			b = 24'($urandom);
			lw <= a;
			rw <= b;
			if (i < keep) expq.push_back({24'(a << (24 - wb)), 24'(b << (24 - wb))});
			do @(posedge mclk_i); while (!frame);
		end
		do @(posedge mclk_i); while (!frame);
		run <= 1'b0;
	endtask
	task automatic drain();
		repeat (3000) if (expq.size() != 0) @(posedge mclk_i);
		check(48'(expq.size()), 48'h0);
	endtask

	// ****************************************
	// clock, far side and output watch
	// ****************************************
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc++;
		gap++;
		oversampling_clock_i <= ~oversampling_clock_i;
		pair_ready_i <= !hold && 1'($urandom);
		if (pair_valid_o === 1'b1 && pair_ready_i) begin
			check(pair_o, expq.size() ? expq.pop_front() : 'x);
		end
		if (biphase_en_o === 1'b1) begin
			if (bp_seen > 1) check(48'(gap), 48'(2 * exp_div));
			bp_seen++;
			gap = 0;
		end
		if (cyc > 40000) begin
			error_cnt++;
			final_report;
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(54));
		{rst_b_i, psel_i, penable_i, pwrite_i, pair_ready_i, run, hold} = '0;
		{paddr_i, pwdata_i, lw, rw, exp_div} = '0;
		oversampling_clock_i = 1'b0;
		fmt = fmt_i2s;
		wid = width_16;
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		apb(1'b0, ctrl_addr, 32'h0, 32'h2, 1'b0);
		apb(1'b0, 4'h2, 32'h0, 32'h0, 1'b1);
		for (int f = 0; f < 3; f++) begin
			for (int w = 0; w < 4; w++) begin
				run_mode(fmt_t'(f), width_t'(w), 4, 4);
				drain();
			end
		end
		hold <= 1'b1;
		run_mode(fmt_i2s, width_24, 4, 2);
		apb(1'b0, status_addr, 32'h0, 32'h3, 1'b0);
		apb(1'b1, status_addr, 32'h1, 32'h0, 1'b0);
		apb(1'b0, status_addr, 32'h0, 32'h2, 1'b0);
		hold <= 1'b0;
		drain();
		apb(1'b0, status_addr, 32'h0, 32'h0, 1'b0);
		final_report;
	end
endmodule

bind spdif_serial_input spdif_serial_input_properties chk (.mclk_i, .rst_b_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
	.bit_clock_i, .word_clock_i, .serial_sample_line_i, .oversampling_clock_i,
	.biphase_en_o, .pair_valid_o, .pair_ready_i, .pair_o);
